// *** design/conv_regs_consts.svh ***
// Function
// - control bit 6 picks low or high span
// - control bit 5 switches converter on or off
// - control bit 3 drives forced PWM enable
// - control bit 2 drives ramp PWM enable
// - control bits 1:0 pick scaling slew rate
// - control bits 7 and 4 stored, no effect
// - status bits 7:2 always read zero
// - overtemp flag sticky, read clears if gone
// - power-not-good flag sticky, read clears if gone
// - identification bits 7:4 fixed maker code
// - identification bits 3:2 major revision code
// - identification bits 1:0 minor revision code
// - setpoint bit 7 reads zero, 6:0 writable
// - setpoint A active while select low, reset 0x3c
// - setpoint B active while select high, reset 0x42
// - control resets 0x00 or 0x20 by variant
// - answer only 7-bit slave address 1110101b
// - unmapped register reads return 00h
// - write commits at falling edge of ack
`ifndef CONV_REGS_CONSTS_SVH
`define CONV_REGS_CONSTS_SVH

`define DEV_ADDR 7'h75
`define REG_CONTROL 8'h01
`define REG_STATUS 8'h02
`define REG_IDENT 8'h03
`define REG_SETPOINT_A 8'h04
`define REG_SETPOINT_B 8'h05

`define CTRL_RESET_OFF 8'h00
`define CTRL_RESET_ON 8'h20
`define SETPOINT_A_RESET 7'h3c
`define SETPOINT_B_RESET 7'h42
`define UNMAPPED_READ 8'h00

`define CTRL_RANGE_BIT 6
`define CTRL_ENABLE_BIT 5
`define CTRL_FORCED_PULSE_MOD_EN_BIT 3
`define CTRL_RAMP_PULSE_MOD_EN_BIT 2
`define CTRL_SLEW_HI 1
`define CTRL_SLEW_LO 0

`define SYNC_W 5
`define SYNC_SCL 4
`define SYNC_SDA 3
`define SYNC_SEL 2
`define SYNC_OT 1
`define SYNC_PNG 0
// bus lines idle high, so they start high to avoid a false start
`define SYNC_RESET 5'h18
`define BYTE_BITS 4'h8
`define LAST_TX_BIT 4'h7

`endif

// *** design/conv_regs_pkg.sv ***
package conv_regs_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEVADDR = 7'h02,
        ST_REGADDR = 7'h04,
        ST_WRDATA = 7'h08,
        ST_ACK = 7'h10,
        ST_RDDATA = 7'h20,
        ST_MACK = 7'h40
    } link_state_e;

    typedef struct packed {
        link_state_e state;
        link_state_e afterAck;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] txByte;
        logic [7:0] ptr;
        logic commitWrite;
        logic [7:0] control;
        logic [6:0] setpointA;
        logic [6:0] setpointB;
        logic [6:0] activeSetpoint;
        logic overtempFlag;
        logic powerNotGoodFlag;
        logic sclPrev;
        logic sdaPrev;
        logic sdaOe;
    } bank_state_s;

endpackage

// *** design/sync_if.sv ***
`timescale 1ns/1ps
interface sync_if #(
    parameter int W = 5
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport producer (input raw, output clean);
    modport consumer (output raw, input clean);
endinterface

// *** design/input_sync.sv ***
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // raw in, filtered out
    sync_if.producer bus
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] out;
    } sync_state_s;

    sync_state_s s_reg;
    sync_state_s s_next;
    logic [W-1:0] outNext;

    // a change only counts once the second and third stage agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign outNext[i] = (s_reg.ff2[i] == s_reg.ff3[i]) ? s_reg.ff3[i] : s_reg.out[i];
    end

    // one process owns the whole next-state copy, so it has a single driver
    always_comb begin
        s_next = s_reg;
        s_next.ff1 = bus.raw;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        s_next.out = outNext;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.clean = s_reg.out;
endmodule

// *** design/converter_config_registers.sv ***
`timescale 1ns/1ps
`include "conv_regs_consts.svh"
module converter_config_registers #(
    parameter bit START_ENABLED = 1'b0,
    // arbitrary neutral maker code
    parameter logic [3:0] MAKER_CODE = 4'h9,
    parameter logic [1:0] MAJOR_REV = 2'h1,
    parameter logic [1:0] MINOR_REV = 2'h0
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // pins and comparator levels
    input wire logic setpointSelectPin,
    input wire logic overtempEvent,
    input wire logic powerNotGoodEvent,
    // converter controls
    output logic rangeHigh,
    output logic converterEnable,
    output logic forcedPulseModEn,
    output logic rampPulseModEn,
    output logic [1:0] slewRate,
    output logic [6:0] activeSetpoint,
    // sticky flags
    output logic overtempFlag,
    output logic powerNotGoodFlag
);
    conv_regs_pkg::bank_state_s s_reg;
    conv_regs_pkg::bank_state_s s_next;

    localparam logic [7:0] CTRL_RESET = START_ENABLED ? `CTRL_RESET_ON : `CTRL_RESET_OFF;

    sync_if #(.W(`SYNC_W)) syncBus ();

    assign syncBus.raw = {sclIn, sdaIn, setpointSelectPin, overtempEvent, powerNotGoodEvent};

    input_sync #(
        .W(`SYNC_W),
        .RESET_VAL(`SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .bus(syncBus.producer)
    );

    logic scl;
    logic sda;
    logic selHigh;
    logic otLevel;
    logic pngLevel;

    assign scl = syncBus.clean[`SYNC_SCL];
    assign sda = syncBus.clean[`SYNC_SDA];
    assign selHigh = syncBus.clean[`SYNC_SEL];
    assign otLevel = syncBus.clean[`SYNC_OT];
    assign pngLevel = syncBus.clean[`SYNC_PNG];

    function automatic logic [7:0] readValue(input conv_regs_pkg::bank_state_s s);
        logic [7:0] v;
        v = `UNMAPPED_READ;
        case (s.ptr)
            `REG_CONTROL: begin
                v = s.control;
            end
            `REG_STATUS: begin
                v = {6'h00, s.overtempFlag, s.powerNotGoodFlag};
            end
            `REG_IDENT: begin
                v = {MAKER_CODE, MAJOR_REV, MINOR_REV};
            end
            `REG_SETPOINT_A: begin
                v = {1'b0, s.setpointA};
            end
            `REG_SETPOINT_B: begin
                v = {1'b0, s.setpointB};
            end
            default: begin
                v = `UNMAPPED_READ;
            end
        endcase
        return v;
    endfunction

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclRise = scl & ~s_reg.sclPrev;
    assign sclFall = ~scl & s_reg.sclPrev;
    assign startCond = scl & s_reg.sclPrev & s_reg.sdaPrev & ~sda;
    assign stopCond = scl & s_reg.sclPrev & ~s_reg.sdaPrev & sda;

    always_comb begin
        logic [7:0] loadVal;
        logic statusRead;
        loadVal = readValue(s_reg);
        statusRead = 1'b0;
        s_next = s_reg;
        s_next.sclPrev = scl;
        s_next.sdaPrev = sda;

        if (startCond) begin
            // repeated start lands here too
            s_next.state = conv_regs_pkg::ST_DEVADDR;
            s_next.bitCnt = 4'h0;
            s_next.sdaOe = 1'b0;
        end else if (stopCond) begin
            s_next.state = conv_regs_pkg::ST_IDLE;
            s_next.sdaOe = 1'b0;
        end else begin
            case (s_reg.state)
                conv_regs_pkg::ST_IDLE: begin
                    s_next.sdaOe = 1'b0;
                end
                conv_regs_pkg::ST_DEVADDR,
                conv_regs_pkg::ST_REGADDR,
                conv_regs_pkg::ST_WRDATA: begin
                    if (sclRise && s_reg.bitCnt != `BYTE_BITS) begin
                        s_next.shift = {s_reg.shift[6:0], sda};
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                    end else if (sclFall && s_reg.bitCnt == `BYTE_BITS) begin
                        s_next.bitCnt = 4'h0;
                        s_next.state = conv_regs_pkg::ST_ACK;
                        s_next.sdaOe = 1'b1;
                        s_next.commitWrite = 1'b0;
                        if (s_reg.state == conv_regs_pkg::ST_DEVADDR) begin
                            if (s_reg.shift[7:1] == `DEV_ADDR) begin
                                s_next.afterAck = s_reg.shift[0] ? conv_regs_pkg::ST_RDDATA
                                                                 : conv_regs_pkg::ST_REGADDR;
                            end else begin
                                // other address: stay off the bus until next start
                                s_next.state = conv_regs_pkg::ST_IDLE;
                                s_next.sdaOe = 1'b0;
                            end
                        end else if (s_reg.state == conv_regs_pkg::ST_REGADDR) begin
                            s_next.ptr = s_reg.shift;
                            s_next.afterAck = conv_regs_pkg::ST_WRDATA;
                        end else begin
                            s_next.afterAck = conv_regs_pkg::ST_WRDATA;
                            s_next.commitWrite = 1'b1;
                        end
                    end
                end
                conv_regs_pkg::ST_ACK: begin
                    if (sclFall) begin
                        s_next.sdaOe = 1'b0;
                        s_next.state = s_reg.afterAck;
                        s_next.bitCnt = 4'h0;
                        if (s_reg.commitWrite) begin
                            case (s_reg.ptr)
                                `REG_CONTROL: begin
                                    s_next.control = s_reg.shift;
                                end
                                `REG_SETPOINT_A: begin
                                    s_next.setpointA = s_reg.shift[6:0];
                                end
                                `REG_SETPOINT_B: begin
                                    s_next.setpointB = s_reg.shift[6:0];
                                end
                                default: begin
                                    s_next.setpointA = s_reg.setpointA;
                                end
                            endcase
                            s_next.ptr = s_reg.ptr + 8'h01;
                            s_next.commitWrite = 1'b0;
                        end
                        if (s_reg.afterAck == conv_regs_pkg::ST_RDDATA) begin
                            s_next.txByte = loadVal;
                            s_next.sdaOe = ~loadVal[7];
                            s_next.ptr = s_reg.ptr + 8'h01;
                            statusRead = (s_reg.ptr == `REG_STATUS);
                        end
                    end
                end
                conv_regs_pkg::ST_RDDATA: begin
                    if (sclFall) begin
                        if (s_reg.bitCnt == `LAST_TX_BIT) begin
                            s_next.state = conv_regs_pkg::ST_MACK;
                            s_next.sdaOe = 1'b0;
                        end else begin
                            s_next.txByte = {s_reg.txByte[6:0], 1'b0};
                            s_next.sdaOe = ~s_reg.txByte[6];
                            s_next.bitCnt = s_reg.bitCnt + 4'h1;
                        end
                    end
                end
                conv_regs_pkg::ST_MACK: begin
                    if (sclRise) begin
                        // master's acknowledge kept in the shift register
                        s_next.shift = {7'h00, sda};
                    end else if (sclFall) begin
                        s_next.bitCnt = 4'h0;
                        if (s_reg.shift[0]) begin
                            s_next.state = conv_regs_pkg::ST_IDLE;
                        end else begin
                            s_next.state = conv_regs_pkg::ST_RDDATA;
                            s_next.txByte = loadVal;
                            s_next.sdaOe = ~loadVal[7];
                            s_next.ptr = s_reg.ptr + 8'h01;
                            statusRead = (s_reg.ptr == `REG_STATUS);
                        end
                    end
                end
                default: begin
                    s_next.state = conv_regs_pkg::ST_IDLE;
                    s_next.sdaOe = 1'b0;
                end
            endcase
        end

        // a live condition re-sets the flag, so it outlasts the read
        s_next.overtempFlag = otLevel | (s_reg.overtempFlag & ~statusRead);
        s_next.powerNotGoodFlag = pngLevel | (s_reg.powerNotGoodFlag & ~statusRead);

        s_next.activeSetpoint = selHigh ? s_reg.setpointB : s_reg.setpointA;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.state <= conv_regs_pkg::ST_IDLE;
            s_reg.afterAck <= conv_regs_pkg::ST_IDLE;
            s_reg.control <= CTRL_RESET;
            s_reg.setpointA <= `SETPOINT_A_RESET;
            s_reg.setpointB <= `SETPOINT_B_RESET;
            s_reg.activeSetpoint <= `SETPOINT_A_RESET;
            s_reg.sclPrev <= 1'b1;
            s_reg.sdaPrev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe = s_reg.sdaOe;

    assign rangeHigh = s_reg.control[`CTRL_RANGE_BIT];
    assign converterEnable = s_reg.control[`CTRL_ENABLE_BIT];
    assign forcedPulseModEn = s_reg.control[`CTRL_FORCED_PULSE_MOD_EN_BIT];
    assign rampPulseModEn = s_reg.control[`CTRL_RAMP_PULSE_MOD_EN_BIT];
    assign slewRate = s_reg.control[`CTRL_SLEW_HI:`CTRL_SLEW_LO];
    assign activeSetpoint = s_reg.activeSetpoint;
    assign overtempFlag = s_reg.overtempFlag;
    assign powerNotGoodFlag = s_reg.powerNotGoodFlag;
endmodule

// *** verification/conv_regs_checker.sv ***
`timescale 1ns/1ps
module conv_regs_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // levels in
    input wire logic setpointSelectPin,
    input wire logic overtempEvent,
    input wire logic powerNotGoodEvent,
    // outputs
    input wire logic rangeHigh,
    input wire logic converterEnable,
    input wire logic forcedPulseModEn,
    input wire logic rampPulseModEn,
    input wire logic [1:0] slewRate,
    input wire logic [6:0] activeSetpoint,
    input wire logic overtempFlag,
    input wire logic powerNotGoodFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [3:0] age_reg;
    wire [5:0] ctlBits = {rangeHigh, converterEnable, forcedPulseModEn, rampPulseModEn, slewRate};
    // select sync after reset may move the setpoint legally
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age_reg <= 4'h0;
        end else if (age_reg != 4'hf) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    sequence quietS;
        (!sdaOe && $stable(setpointSelectPin) && age_reg == 4'hf)[*6];
    endsequence
    sequence otHighS;
        overtempEvent[*5];
    endsequence
    sequence pngHighS;
        powerNotGoodEvent[*5];
    endsequence
    AST_CTL_COMMIT: assert property (
        $changed(ctlBits) |-> !sclIn && ($past(sdaOe, 1) || $past(sdaOe, 2) ||
        $past(sdaOe, 3) || $past(sdaOe, 4) || $past(sdaOe, 5)))
        else $error("control changed outside a write acknowledge");
    AST_OT_SET: assert property (otHighS |-> ##[0:3] overtempFlag)
        else $error("overtemp flag not set");
    AST_PNG_SET: assert property (pngHighS |-> ##[0:3] powerNotGoodFlag)
        else $error("power flag not set");
    AST_OT_CLEAR: assert property ($fell(overtempFlag) |->
        !$past(overtempEvent, 2) || !$past(overtempEvent, 3) || !$past(overtempEvent, 4))
        else $error("overtemp flag cleared while condition present");
    AST_PNG_CLEAR: assert property ($fell(powerNotGoodFlag) |->
        !$past(powerNotGoodEvent, 2) || !$past(powerNotGoodEvent, 3) ||
        !$past(powerNotGoodEvent, 4))
        else $error("power flag cleared while condition present");
    AST_SEL_HOLD: assert property (quietS |=> $stable(activeSetpoint))
        else $error("setpoint moved without cause");
    AST_ACK_LOW_SCL: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn, 2))
        else $error("data line pulled while clock high");
    AST_SDA_STEADY: assert property (sclIn [*4] |-> $stable(sdaOe))
        else $error("data line moved during clock high");
endmodule
bind converter_config_registers conv_regs_checker chk_u (.clk, .arst_n, .sclIn, .sdaIn,
    .sdaOut, .sdaOe, .setpointSelectPin, .overtempEvent, .powerNotGoodEvent, .rangeHigh,
    .converterEnable, .forcedPulseModEn, .rampPulseModEn, .slewRate, .activeSetpoint,
    .overtempFlag, .powerNotGoodFlag);

// *** verification/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic clk,
    output logic scl,
    output logic sdaLow,
    input wire logic sdaWire
);
    // 8 clocks per half bit clears the 6-clock minimum
    localparam int HALF = 8;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic bitIo(input logic b, output logic r);
        sdaLow = !b;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        r = sdaWire;
        scl = 1'b0;
        pause(2);
    endtask
    task automatic start();
        sdaLow = 1'b0;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        sdaLow = 1'b1;
        pause(HALF);
        scl = 1'b0;
        pause(2);
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        sdaLow = 1'b0;
        pause(HALF);
    endtask
    task automatic byteOut(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(v[i], r);
        end
        bitIo(1'b1, r);
        ack = !r;
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] v, output logic ack);
        logic k;
        start();
        byteOut(8'hea, ack);
        byteOut(a, k);
        ack &= k;
        byteOut(v, k);
        ack &= k;
        stop();
    endtask
    task automatic regRead(input logic [7:0] a, output logic [7:0] v, output logic ack);
        logic k;
        start();
        byteOut(8'hea, ack);
        byteOut(a, k);
        ack &= k;
        start();
        byteOut(8'heb, k);
        ack &= k;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, v[i]);
        end
        bitIo(1'b1, k);
        stop();
    endtask
endmodule

// *** verification/test_converter_config_registers.sv ***
`timescale 1ns/1ps
`define CMP(got, exp) begin \
    totalChecks++; \
    if ((got) !== (exp)) begin \
        errTotal++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module test_converter_config_registers;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sel = 1'b0;
    logic otEv = 1'b0;
    logic pngEv = 1'b0;
    logic scl, hostLow, sdaOut, sdaOe, ack;
    logic rangeHigh, converterEnable, forcedPulseModEn, rampPulseModEn;
    logic overtempFlag, powerNotGoodFlag;
    logic [1:0] slewRate;
    logic [6:0] activeSetpoint;
    logic [7:0] d;
    int errTotal = 0;
    int totalChecks = 0;
    int cyc = 0;
    int mdl [0:7];
    wire sdaWire = !(hostLow || sdaOe);
    wire [5:0] ctlOut = {rangeHigh, converterEnable, forcedPulseModEn, rampPulseModEn, slewRate};
    always #20 clk = ~clk;
    i2c_host_model host (.clk, .scl, .sdaLow(hostLow), .sdaWire);
    // maker and revision codes are arbitrary
    converter_config_registers #(.START_ENABLED(1'b1), .MAKER_CODE(4'h6), .MAJOR_REV(2'h2),
        .MINOR_REV(2'h3)) dut_u (.clk, .arst_n, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOe,
        .setpointSelectPin(sel), .overtempEvent(otEv), .powerNotGoodEvent(pngEv), .rangeHigh,
        .converterEnable, .forcedPulseModEn, .rampPulseModEn, .slewRate, .activeSetpoint,
        .overtempFlag, .powerNotGoodFlag);
    task automatic summarize();
        if (errTotal == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic readChk(input int a);
        host.regRead(8'(a), d, ack);
        `CMP(ack, 1'b1)
        `CMP(d, 8'(mdl[a]))
        // a status read only clears flags whose condition is gone
        if (a == 2) mdl[2] &= {otEv, pngEv};
    endtask
    task automatic wr(input int a, input logic [7:0] v);
        host.regWrite(8'(a), v, ack);
        `CMP(ack, 1'b1)
        if (a == 1) mdl[1] = v;
        if (a == 4 || a == 5) mdl[a] = v & 8'h7f;
    endtask
    task automatic chkOut();
        repeat (8) @(negedge clk);
        `CMP(ctlOut, 6'({mdl[1][6:5], mdl[1][3:0]}))
        `CMP(activeSetpoint, 7'(sel ? mdl[5] : mdl[4]))
        `CMP({overtempFlag, powerNotGoodFlag}, 2'(mdl[2]))
        `CMP(sdaOut, 1'b0)
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errTotal++;
            summarize();
        end
    end
    initial begin
        d = 8'($urandom(55));
        mdl = '{0, 32'h20, 0, 32'h6b, 32'h3c, 32'h42, 0, 0};
        repeat (20) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        chkOut();
        for (int a = 0; a < 8; a++) begin
            readChk(a);
        end
        for (int i = 0; i < 4; i++) begin
            d = (8'($urandom) & 8'hfc) | 8'(i);
            if (i == 1) d = d | 8'hfc;
            wr(1, d);
            chkOut();
            readChk(1);
        end
        wr(4, 8'hff);
        wr(5, 8'($urandom));
        wr(3, 8'h55);
        wr(2, 8'h03);
        wr(6, 8'h5a);
        for (int a = 2; a < 7; a++) begin
            readChk(a);
        end
        @(negedge clk);
        sel = 1'b1;
        chkOut();
        @(negedge clk);
        sel = 1'b0;
        chkOut();
        host.start();
        host.byteOut(8'hd4, ack);
        host.stop();
        `CMP(ack, 1'b0)
        for (int f = 0; f < 2; f++) begin
            @(negedge clk);
            {otEv, pngEv} = f ? 2'b01 : 2'b10;
            mdl[2] = f ? 1 : 2;
            chkOut();
            readChk(2);
            chkOut();
            @(negedge clk);
            {otEv, pngEv} = 2'b00;
            chkOut();
            readChk(2);
            readChk(2);
            chkOut();
        end
        @(negedge clk);
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        mdl = '{0, 32'h20, 0, 32'h6b, 32'h3c, 32'h42, 0, 0};
        chkOut();
        readChk(1);
        summarize();
    end
endmodule
